// >>> logic/asc_params.svh
// constants of the converter sequencer: offsets, fields, reset values, counts
// Contract
// [RL1] set sequence complete flag per finished sequence
// [RL2] set conversion flag when result register loads
// [RL3] sample phases: 2, 4, then 2/4/8/16 clocks
// [RL4] convert 10 or 12 clocks, then store result
// [RL5] 8 or 10 bit binary search
// [RL6] prescaler divides 1..32, then by two
// [RL7] continuous sequence stops on stop or wait
// [RL8] power down: bit clear, stop, wait
// [RL9] power-up bit resets to zero
// [RL10] power down aborts sequence, stops clocks
// [RL11] power-up keeps registers; software waits bias
// [RL12] registers accessible in program power down
// [RL13] no register access in wait power down
// [RL14] stop-in-wait clear ignores wait signal
// [RL15] gate submodule clocks when not active
// [RL16] freeze select: ignore, finish, or immediate
// [RL17] freeze holds state, allows register access
// [RL18] soft reset keeps power-up bit, goes idle
// [RL19] module reset ends sequence, clears flags
// [RL20] leaving wait power down resumes unchanged
// [RL21] terminating freeze leaves module idle
// [RL22] control four/five write restarts, clears flags
// [RL23] continuous runs until stopped or replaced
// [RL24] scan, multi-channel, special-conversion bits
// [RL25] sequence length of 1, 4 or 8
`ifndef ASC_PARAMS_SVH
`define ASC_PARAMS_SVH
// ==========================================
// register offsets
`define ASC_OFF_CTL2 4'h0
`define ASC_OFF_CTL3 4'h1
`define ASC_OFF_CTL4 4'h2
`define ASC_OFF_CTL5 4'h3
`define ASC_OFF_STAT 4'h4
`define ASC_OFF_CCF 4'h5
`define ASC_OFF_TEST 4'h6
// ==========================================
// field positions
`define ASC_CTL2_PU 7
`define ASC_CTL2_SIW 6
`define ASC_CTL3_S1C 3
`define ASC_CTL3_FRZ 0
`define ASC_CTL4_RES10 7
`define ASC_CTL4_SMP 5
`define ASC_CTL4_PRS 0
`define ASC_CTL5_S8C 6
`define ASC_CTL5_SCAN 5
`define ASC_CTL5_MULTI_CHANNEL_BIT 4
`define ASC_CTL5_SC 3
`define ASC_CTL5_CH 0
`define ASC_STAT_SCF 15
`define ASC_STAT_BUSY 14
`define ASC_TEST_SRST 0
// ==========================================
// reset values
`define ASC_RST_FRZ 2'h0
`define ASC_RST_SMP 2'h0
`define ASC_RST_PRS 5'h01
`define ASC_RST_CH 3'h0
// ==========================================
// freeze responses and phase lengths in module clocks
`define ASC_FRZ_IGN 2'h0
`define ASC_FRZ_FIN 2'h1
`define ASC_FRZ_NOW 2'h2
`define ASC_FRZ_ABT 2'h3
`define ASC_CAP_CLKS 5'h02
`define ASC_AMP_CLKS 5'h04
`define ASC_DIR_BASE 5'h02
`define ASC_CONV8_CLKS 5'h0a
`define ASC_CONV10_CLKS 5'h0c
`endif

// >>> logic/asc_pkg.sv
// types of the converter sequencer
package asc_pkg;
  typedef enum logic [5:0] {
    ASC_IDLE = 6'b000001,
    ASC_NEXT = 6'b000010,
    ASC_SCAP = 6'b000100,
    ASC_SAMP = 6'b001000,
    ASC_SDIR = 6'b010000,
    ASC_CONV = 6'b100000
  } asc_state_t;
  typedef struct packed {
    logic [4:0] cnt;
    logic half;
  } asc_div_st_t;
  typedef struct packed {
    logic pu;
    logic siw;
    logic s1c;
    logic [1:0] frz;
    logic res10;
    logic [1:0] smp;
    logic [4:0] prs;
    logic s8c;
    logic scan;
    logic multi_channel_bit;
    logic sc;
    logic [2:0] ch;
    logic [7:0] ccf;
    logic sequence_complete_flag;
    logic [7:0][9:0] res;
    asc_state_t st;
    logic [4:0] cnt;
    logic [2:0] idx;
    logic [2:0] chan;
    logic [9:0] approximation_register;
    logic [9:0] trial;
    logic cmp_m;
    logic cmp_s;
    logic stop_m;
    logic stop_s;
    logic wait_m;
    logic wait_s;
    logic dbg_m;
    logic dbg_s;
    logic [15:0] rdata;
  } asc_top_st_t;
endpackage

// >>> logic/asc_prescaler.sv
// module clock prescaler: five bit modulus counter and a divide by two
`timescale 1ns/1ps
`default_nettype none
module asc_prescaler (
  input wire logic core_clk, // peripheral clock
  input wire logic rst, // asynchronous reset, active high
  input wire logic run, // low clears the counter
  input wire logic hold, // keeps the count where it stands
  input wire logic [4:0] div, // divide by div plus one
  output logic tick // one module clock step
);
  import asc_pkg::*;
  asc_div_st_t s;
  asc_div_st_t next_s;

  // ==========================================
  // counter
  // a tick every 2*(div+1) peripheral clocks
  assign tick = run & ~hold & s.half & (s.cnt == div); // RL6
  always_comb
  begin
    next_s = s;
    if (!run)
    begin
      next_s = '0; // digital clocks stopped
    end
    else if (!hold)
    begin
      if (s.cnt == div) // RL6
      begin
        next_s.cnt = 5'h00;
        next_s.half = ~s.half;
      end
      else
      begin
        next_s.cnt = s.cnt + 5'h01;
      end
    end
  end

  // state register
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      s <= '0;
    else
      s <= next_s;
  end
endmodule
`default_nettype wire

// >>> logic/asc_top.sv
// converter sequencer: registers, sample timing, approximation and power modes
`timescale 1ns/1ps
`default_nettype none
`include "asc_params.svh"
module asc_top (
  input wire logic core_clk, // peripheral clock, 125 MHz
  input wire logic rst, // system reset, asynchronous, active high
  input wire logic [3:0] addr, // register address
  input wire logic [15:0] wdata, // write data
  input wire logic wr, // write strobe
  input wire logic rd, // read strobe
  output logic [15:0] rdata, // read data, cycle after the strobe
  input wire logic cmp_in, // comparator: sample at or above reference
  input wire logic stop_req, // processor stop level
  input wire logic wait_req, // processor wait level
  input wire logic debug_mode_signal, // debug freeze request level
  output logic [2:0] mux_chan, // analog input channel
  output logic ref_conv, // convert internal reference levels
  output logic sample_cap_on, // input onto sample capacitor
  output logic sample_amp_on, // buffer amplifier charges storage node
  output logic sample_direct_on, // input straight onto storage node
  output logic [9:0] dac_code, // approximation register to the arrays
  output logic sh_clk_en, // sample stage clock enable
  output logic conv_clk_en, // conversion stage clock enable
  output logic analog_power_on, // analog bias enable
  output logic seq_complete, // sequence complete flag
  output logic busy // sequence in progress
);
  import asc_pkg::*;
  asc_top_st_t s;
  asc_top_st_t next_s;
  logic tick;
  logic pd_off;
  logic pd_wait;
  logic hold;
  logic acc_ok;
  logic restart;
  logic srst;
  logic frz_fin;
  logic frz_abt;
  logic [2:0] last_idx;
  logic [4:0] dir_len;
  logic [4:0] conv_len;
  logic [9:0] top_bit;

  // ==========================================
  // power, freeze and access conditions
  // program power down and stop abort; wait power down only holds
  assign pd_off = ~s.pu | s.stop_s; // RL8 RL9 RL7
  assign pd_wait = s.wait_s & s.siw; // RL14 RL8
  assign frz_fin = s.dbg_s & (s.frz == `ASC_FRZ_FIN); // RL16
  assign frz_abt = s.dbg_s & (s.frz == `ASC_FRZ_ABT); // RL21
  assign hold = pd_wait | (s.dbg_s & (s.frz == `ASC_FRZ_NOW)); // RL17 RL20
  assign acc_ok = ~pd_wait; // RL13 RL12 RL17
  assign restart = wr & acc_ok & ((addr == `ASC_OFF_CTL4) | (addr == `ASC_OFF_CTL5));
  assign srst = wr & acc_ok & (addr == `ASC_OFF_TEST) & wdata[`ASC_TEST_SRST];

  // sequence shape and phase lengths
  assign last_idx = s.s8c ? 3'h7 : (s.s1c ? 3'h0 : 3'h3); // RL25
  assign dir_len = `ASC_DIR_BASE << s.smp; // RL3
  assign conv_len = s.res10 ? `ASC_CONV10_CLKS : `ASC_CONV8_CLKS; // RL4
  assign top_bit = s.res10 ? 10'h200 : 10'h080; // RL5

  // ==========================================
  // module clock
  // the prescaler only runs while a sequence is live, so idle costs no toggles
  asc_prescaler u_prescaler (
    .core_clk(core_clk),
    .rst(rst),
    .run(~pd_off & (s.st != ASC_IDLE)), // RL10 RL15
    .hold(hold),
    .div(s.prs),
    .tick(tick)
  );

  // ==========================================
  // next state
  always_comb
  begin
    next_s = s;
    // comparator, stop, wait and debug pins pass two flip-flops before any logic reads them
    next_s.cmp_m = cmp_in;
    next_s.cmp_s = s.cmp_m;
    next_s.stop_m = stop_req;
    next_s.stop_s = s.stop_m;
    next_s.wait_m = wait_req;
    next_s.wait_s = s.wait_m;
    next_s.dbg_m = debug_mode_signal;
    next_s.dbg_s = s.dbg_m;

    // register reads, blocked during wait power down
    next_s.rdata = 16'h0000;
    if (rd & acc_ok) // RL13
    begin
      if (addr[3])
      begin
        next_s.rdata = {6'h00, s.res[addr[2:0]]};
        next_s.ccf[addr[2:0]] = 1'b0; // a result read retires its flag
      end
      else
      begin
        unique case (addr)
          `ASC_OFF_CTL2: next_s.rdata = {8'h00, s.pu, s.siw, 6'h00};
          `ASC_OFF_CTL3: next_s.rdata = {12'h000, s.s1c, 1'b0, s.frz};
          `ASC_OFF_CTL4: next_s.rdata = {8'h00, s.res10, s.smp, s.prs};
          `ASC_OFF_CTL5: next_s.rdata = {9'h000, s.s8c, s.scan, s.multi_channel_bit, s.sc, s.ch};
          `ASC_OFF_STAT: next_s.rdata = {s.sequence_complete_flag, s.st != ASC_IDLE, 11'h000, s.idx};
          `ASC_OFF_CCF: next_s.rdata = {8'h00, s.ccf};
          default: next_s.rdata = 16'h0000;
        endcase
      end
    end

    // register writes; powered-down program mode still takes them
    if (wr & acc_ok) // RL12
    begin
      unique case (addr)
        `ASC_OFF_CTL2:
        begin
          next_s.pu = wdata[`ASC_CTL2_PU]; // RL11
          next_s.siw = wdata[`ASC_CTL2_SIW];
        end
        `ASC_OFF_CTL3:
        begin
          next_s.s1c = wdata[`ASC_CTL3_S1C];
          next_s.frz = wdata[`ASC_CTL3_FRZ +: 2]; // RL16
        end
        `ASC_OFF_CTL4:
        begin
          next_s.res10 = wdata[`ASC_CTL4_RES10];
          next_s.smp = wdata[`ASC_CTL4_SMP +: 2];
          next_s.prs = wdata[`ASC_CTL4_PRS +: 5];
        end
        `ASC_OFF_CTL5:
        begin
          next_s.s8c = wdata[`ASC_CTL5_S8C];
          next_s.scan = wdata[`ASC_CTL5_SCAN]; // RL24
          next_s.multi_channel_bit = wdata[`ASC_CTL5_MULTI_CHANNEL_BIT]; // RL24
          next_s.sc = wdata[`ASC_CTL5_SC]; // RL24
          next_s.ch = wdata[`ASC_CTL5_CH +: 3];
        end
        default:
        begin
        end
      endcase
    end

    // ==========================================
    // sequencer
    if (pd_off)
    begin
      next_s.st = ASC_IDLE; // RL10 RL7 RL23
    end
    else if (frz_abt & (s.st != ASC_IDLE))
    begin
      next_s.st = ASC_IDLE; // RL21
    end
    else if (restart)
    begin
      next_s.ccf = 8'h00; // RL22
      next_s.sequence_complete_flag = 1'b0; // RL22
      next_s.idx = 3'h0;
      next_s.st = ASC_NEXT; // RL22
    end
    else if (!hold)
    begin
      unique case (s.st)
        ASC_IDLE:
        begin
        end
        ASC_NEXT:
        begin
          // a finishing freeze parks here, before the next sample starts
          if (!frz_fin) // RL16
          begin
            next_s.chan = s.multi_channel_bit ? s.ch + s.idx : s.ch; // RL24
            next_s.cnt = 5'h00;
            next_s.st = ASC_SCAP;
          end
        end
        ASC_SCAP:
        begin
          if (tick)
          begin
            next_s.cnt = s.cnt + 5'h01;
            if (s.cnt == `ASC_CAP_CLKS - 5'h01) // RL3
            begin
              next_s.cnt = 5'h00;
              next_s.st = ASC_SAMP;
            end
          end
        end
        ASC_SAMP:
        begin
          if (tick)
          begin
            next_s.cnt = s.cnt + 5'h01;
            if (s.cnt == `ASC_AMP_CLKS - 5'h01) // RL3
            begin
              next_s.cnt = 5'h00;
              next_s.st = ASC_SDIR;
            end
          end
        end
        ASC_SDIR:
        begin
          if (tick)
          begin
            next_s.cnt = s.cnt + 5'h01;
            if (s.cnt == dir_len - 5'h01) // RL3
            begin
              next_s.cnt = 5'h00;
              next_s.approximation_register = top_bit; // RL5
              next_s.trial = top_bit;
              next_s.st = ASC_CONV;
            end
          end
        end
        ASC_CONV:
        begin
          if (tick)
          begin
            next_s.cnt = s.cnt + 5'h01;
            // binary search: keep the trial bit if the sample is at or above it
            if (s.trial != 10'h000) // RL5
            begin
              next_s.approximation_register = (s.cmp_s ? s.approximation_register : (s.approximation_register & ~s.trial)) | (s.trial >> 1);
              next_s.trial = s.trial >> 1;
            end
            if (s.cnt == conv_len - 5'h01) // RL4
            begin
              next_s.res[s.idx] = s.approximation_register; // RL4
              next_s.ccf[s.idx] = 1'b1; // RL2
              next_s.cnt = 5'h00;
              if (s.idx == last_idx)
              begin
                next_s.sequence_complete_flag = 1'b1; // RL1
                next_s.idx = 3'h0;
                next_s.st = s.scan ? ASC_NEXT : ASC_IDLE; // RL23 RL24
              end
              else
              begin
                next_s.idx = s.idx + 3'h1;
                next_s.st = ASC_NEXT;
              end
            end
          end
        end
      endcase
    end

    // ==========================================
    // soft module reset: power-up bit and results survive
    if (srst)
    begin
      next_s.siw = 1'b0; // RL18 RL19
      next_s.s1c = 1'b0;
      next_s.frz = `ASC_RST_FRZ;
      next_s.res10 = 1'b0;
      next_s.smp = `ASC_RST_SMP;
      next_s.prs = `ASC_RST_PRS;
      next_s.s8c = 1'b0;
      next_s.scan = 1'b0;
      next_s.multi_channel_bit = 1'b0;
      next_s.sc = 1'b0;
      next_s.ch = `ASC_RST_CH;
      next_s.ccf = 8'h00; // RL19
      next_s.sequence_complete_flag = 1'b0; // RL19
      next_s.idx = 3'h0;
      next_s.cnt = 5'h00;
      next_s.st = ASC_IDLE; // RL18
    end
  end

  // ==========================================
  // state register
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      s <= '0; // RL9 RL19
      s.st <= ASC_IDLE;
      s.prs <= `ASC_RST_PRS;
    end
    else
    begin
      s <= next_s;
    end
  end

  // ==========================================
  // outputs
  // submodule clocks run only in their own phases
  assign rdata = s.rdata;
  assign mux_chan = s.chan;
  assign ref_conv = s.sc;
  assign sample_cap_on = s.st[2];
  assign sample_amp_on = s.st[3];
  assign sample_direct_on = s.st[4];
  assign dac_code = s.approximation_register;
  assign sh_clk_en = (s.st[2] | s.st[3] | s.st[4]) & ~hold; // RL15
  assign conv_clk_en = s.st[5] & ~hold; // RL15
  assign analog_power_on = ~pd_off & ~pd_wait; // RL8
  assign seq_complete = s.sequence_complete_flag;
  assign busy = ~s.st[0];
endmodule
`default_nettype wire

// >>> verification/asc_partner.sv
// comparator and sample stage model standing at the analog side
`timescale 1ns/1ps
`default_nettype none
module asc_partner (
  input wire logic core_clk, // peripheral clock
  input wire logic [2:0] mux_chan, // selected input
  input wire logic sample_direct_on, // final sample phase
  input wire logic [9:0] dac_code, // trial code
  output logic cmp_in // held level at or above trial
);
  logic [9:0] held = 10'h000;
  // each channel sits at its own level, so a wrong slot shows in the result
  always_ff @(posedge core_clk)
  begin
    if (sample_direct_on)
      held <= {mux_chan, 7'h55};
    cmp_in <= held >= dac_code;
  end
endmodule
`default_nettype wire

// >>> verification/asc_checker.sv
// assertion checker for the converter sequencer ports
`timescale 1ns/1ps
`default_nettype none
module asc_checker (
  input wire logic core_clk, // clock
  input wire logic rst, // reset
  input wire logic [3:0] addr, // address
  input wire logic [15:0] wdata, // write data
  input wire logic wr, // write
  input wire logic rd, // read
  input wire logic [15:0] rdata, // read data
  input wire logic stop_req, // stop
  input wire logic wait_req, // wait
  input wire logic debug_mode_signal, // freeze
  input wire logic [9:0] dac_code, // trial code
  input wire logic sample_cap_on, // capacitor phase
  input wire logic sample_amp_on, // amp phase
  input wire logic sample_direct_on, // direct phase
  input wire logic sh_clk_en, // sample clock
  input wire logic conv_clk_en, // convert clock
  input wire logic analog_power_on, // bias
  input wire logic seq_complete, // flag
  input wire logic busy // running
);
  // ==========================================
  // shadow of the control fields
  logic pu, siw;
  logic [1:0] frz, smp;
  logic [4:0] prs;
  logic [11:0] amp_n, dir_n, amp_x, dir_x;
  logic [11:0] cap_n, cap_x;
  // capacitor phase starts off a tick boundary, so it lies between one and two ticks long
  assign cap_x = {5'h00, prs, 2'h0} + 12'h004;
  // phase lengths in core cycles, one tick is 2*(prs+1)
  assign amp_x = {4'h0, prs, 3'h0} + 12'h008;
  assign dir_x = ({7'h00, prs} + 12'h001) << ({1'b0, smp} + 3'h2);
  // held cycles are skipped, so a frozen phase still ends on the exact figure
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      {pu, siw, frz, smp} <= 6'h00;
      prs <= 5'h01;
      amp_n <= 12'h000;
      dir_n <= 12'h000;
      cap_n <= 12'h000;
    end
    else
    begin
      if (wr && addr == 4'h0)
        {pu, siw} <= wdata[7:6];
      if (wr && addr == 4'h1)
        frz <= wdata[1:0];
      if (wr && addr == 4'h2)
        {smp, prs} <= wdata[6:0];
      if (wr && addr == 4'h6 && wdata[0])
      begin
        {siw, frz, smp} <= 5'h00;
        prs <= 5'h01;
      end
      cap_n <= sample_cap_on ? cap_n + {11'h000, sh_clk_en} : 12'h000;
      amp_n <= sample_amp_on ? amp_n + {11'h000, sh_clk_en} : 12'h000;
      dir_n <= sample_direct_on ? dir_n + {11'h000, sh_clk_en} : 12'h000;
    end
  end
  // ==========================================
  // assertions
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  sequence wait_pd;
    wait_req [*4] ##0 (siw && pu);
  endsequence
  sequence frozen;
    debug_mode_signal [*4] ##0 (frz == 2'h2);
  endsequence
  chk_cap_len: assert property (
    $fell(sample_cap_on) && busy && !$past(wr) |->
      sample_amp_on && cap_n <= cap_x && cap_n > (cap_x >> 1))
    else $error("capacitor phase length wrong");
  chk_amp_len: assert property (
    $fell(sample_amp_on) && sample_direct_on && !$past(wr) |-> amp_n == amp_x)
    else $error("amplifier phase length wrong");
  chk_direct_len: assert property (
    $fell(sample_direct_on) && busy && !$past(wr) |-> dir_n == dir_x)
    else $error("direct phase length wrong");
  chk_pd_abort: assert property (
    wr && addr == 4'h0 && !wdata[7] |-> ##[1:2] (!busy && !analog_power_on))
    else $error("power down did not abort");
  chk_stop_abort: assert property (
    stop_req [*5] |-> !busy && !analog_power_on)
    else $error("stop did not abort");
  chk_wait_nobus: assert property ((wait_pd ##0 rd) |=> rdata == 16'h0000)
    else $error("register read during wait power down");
  chk_wait_hold: assert property (wait_pd |=> $stable(dac_code) && $stable(busy))
    else $error("state moved in wait power down");
  chk_freeze_hold: assert property (
    frozen |-> !sh_clk_en && !conv_clk_en ##1 $stable(dac_code))
    else $error("freeze did not hold");
  chk_gate_idle: assert property (!busy |-> !sh_clk_en && !conv_clk_en)
    else $error("clock enable while idle");
  chk_srst_idle: assert property (
    wr && addr == 4'h6 && wdata[0] |=> ##[0:1] (!busy && !seq_complete))
    else $error("soft reset left module busy");
  chk_rd_stand: assert property (!$past(rd) |-> rdata == 16'h0000)
    else $error("read data outside its cycle");
endmodule
`default_nettype wire

// >>> verification/asc_top_tb.sv
// testbench of the converter sequencer
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin #1; total_checks++; if ((a) !== (b)) begin num_errors++; \
  $display("unexpected at %0t: got %h want %h", $time, (a), (b)); end end
module asc_top_tb;
  logic core_clk, rst, wr, rd, stop_req, wait_req, debug_mode_signal, cmp_in;
  logic [3:0] addr;
  logic [15:0] wdata, rdata;
  logic [2:0] mux_chan;
  logic [9:0] dac_code;
  logic ref_conv, sample_cap_on, sample_amp_on, sample_direct_on;
  logic sh_clk_en, conv_clk_en, analog_power_on, seq_complete, busy;
  int num_errors = 0;
  int total_checks = 0;
  logic [15:0] c3 [3] = '{16'h0008, 16'h0000, 16'h0000};
  logic [15:0] c5 [3] = '{16'h0010, 16'h0010, 16'h0050};
  logic [15:0] cf [3] = '{16'h0001, 16'h000f, 16'h00ff};
  // ==========================================
  // design, analog side model and clock
  asc_top uut (.core_clk, .rst, .addr, .wdata, .wr, .rd, .rdata, .cmp_in, .stop_req,
    .wait_req, .debug_mode_signal, .mux_chan, .ref_conv, .sample_cap_on, .sample_amp_on,
    .sample_direct_on, .dac_code, .sh_clk_en, .conv_clk_en, .analog_power_on,
    .seq_complete, .busy);
  asc_partner far (.core_clk, .mux_chan, .sample_direct_on, .dac_code, .cmp_in);
  initial
  begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  // ==========================================
  // bus tasks
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge core_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge core_clk);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [15:0] e);
    @(posedge core_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge core_clk);
    rd <= 1'b0;
    `CHK(rdata, e)
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // bounded wait for the sequence to go idle
  task automatic wt();
    int n;
    n = 0;
    repeat (3) @(posedge core_clk);
    #1;
    while (busy !== 1'b0 && n < 4000)
    begin
      @(posedge core_clk);
      #1;
      n++;
    end
    if (n >= 4000)
    begin
      num_errors++;
      end_of_test();
    end
  endtask
  // ==========================================
  // scenarios
  initial
  begin
    {rst, addr, wdata, wr, rd, stop_req, wait_req, debug_mode_signal} = 26'h2000000;
    repeat (10) @(posedge core_clk);
    rst <= 1'b0;
    rd_chk(4'h0, 16'h0000);
    rd_chk(4'h2, 16'h0001);
    `CHK(analog_power_on, 1'b0)
    wr_reg(4'h0, 16'h0080);
    wr_reg(4'h1, 16'h0008);
    wr_reg(4'h2, 16'h0083);
    wr_reg(4'h3, 16'h0005);
    wt();
    `CHK(seq_complete, 1'b1)
    rd_chk(4'h5, 16'h0001);
    rd_chk(4'h8, 16'h02d5);
    rd_chk(4'h5, 16'h0000);
    wr_reg(4'h2, 16'h0081);
    for (int i = 0; i < 3; i++)
    begin
      wr_reg(4'h1, c3[i]);
      wr_reg(4'h3, c5[i]);
      wt();
      rd_chk(4'h5, cf[i]);
      rd_chk(4'h8, 16'h0055);
    end
    rd_chk(4'hf, 16'h03d5);
    wr_reg(4'h3, 16'h0020);
    repeat (700) @(posedge core_clk);
    `CHK(busy, 1'b1)
    stop_req <= 1'b1;
    repeat (6) @(posedge core_clk);
    `CHK(busy, 1'b0)
    stop_req <= 1'b0;
    repeat (6) @(posedge core_clk);
    wr_reg(4'h3, 16'h0020);
    repeat (50) @(posedge core_clk);
    wr_reg(4'h0, 16'h0000);
    repeat (2) @(posedge core_clk);
    `CHK(busy, 1'b0)
    wr_reg(4'h2, 16'h00e1);
    rd_chk(4'h2, 16'h00e1);
    wr_reg(4'h0, 16'h0080);
    rd_chk(4'h2, 16'h00e1);
    // wait is ignored first, then it powers the module down mid-sequence
    wr_reg(4'h3, 16'h0000);
    wait_req <= 1'b1;
    repeat (6) @(posedge core_clk);
    `CHK(analog_power_on, 1'b1)
    rd_chk(4'h2, 16'h00e1);
    wait_req <= 1'b0;
    wt();
    wr_reg(4'h0, 16'h00c0);
    wr_reg(4'h3, 16'h0000);
    repeat (40) @(posedge core_clk);
    wait_req <= 1'b1;
    repeat (6) @(posedge core_clk);
    `CHK(analog_power_on, 1'b0)
    rd_chk(4'h2, 16'h0000);
    `CHK(busy, 1'b1)
    repeat (100) @(posedge core_clk);
    wait_req <= 1'b0;
    wt();
    rd_chk(4'h5, 16'h000f);
    // freeze responses: immediate, terminate, finish then park
    wr_reg(4'h0, 16'h0080);
    wr_reg(4'h1, 16'h0002);
    wr_reg(4'h3, 16'h0000);
    repeat (40) @(posedge core_clk);
    debug_mode_signal <= 1'b1;
    repeat (200) @(posedge core_clk);
    rd_chk(4'h2, 16'h00e1);
    `CHK(busy, 1'b1)
    debug_mode_signal <= 1'b0;
    wt();
    rd_chk(4'h5, 16'h000f);
    wr_reg(4'h1, 16'h0003);
    wr_reg(4'h3, 16'h0000);
    repeat (40) @(posedge core_clk);
    debug_mode_signal <= 1'b1;
    repeat (6) @(posedge core_clk);
    debug_mode_signal <= 1'b0;
    repeat (6) @(posedge core_clk);
    `CHK(busy, 1'b0)
    rd_chk(4'h2, 16'h00e1);
    wr_reg(4'h1, 16'h0001);
    wr_reg(4'h3, 16'h0000);
    repeat (40) @(posedge core_clk);
    debug_mode_signal <= 1'b1;
    repeat (200) @(posedge core_clk);
    `CHK(busy, 1'b1)
    rd_chk(4'h5, 16'h0001);
    debug_mode_signal <= 1'b0;
    wt();
    wr_reg(4'h3, 16'h0000);
    rd_chk(4'h5, 16'h0000);
    wt();
    // soft reset keeps the power-up bit, returns the other control fields to reset values and clears flags
    wr_reg(4'h6, 16'h0001);
    rd_chk(4'h0, 16'h0080);
    rd_chk(4'h2, 16'h0001);
    rd_chk(4'h1, 16'h0000);
    rd_chk(4'h5, 16'h0000);
    rd_chk(4'h7, 16'h0000);
    wr_reg(4'h3, 16'h0008);
    `CHK(ref_conv, 1'b1)
    // freeze select back at ignore: a debug request must not stall the sequence
    debug_mode_signal <= 1'b1;
    wt();
    `CHK(seq_complete, 1'b1)
    debug_mode_signal <= 1'b0;
    end_of_test();
  end
endmodule
bind asc_top asc_checker chk (.core_clk, .rst, .addr, .wdata, .wr, .rd, .rdata, .stop_req,
  .wait_req, .debug_mode_signal, .dac_code, .sample_cap_on, .sample_amp_on,
  .sample_direct_on, .sh_clk_en, .conv_clk_en, .analog_power_on, .seq_complete, .busy);
`default_nettype wire
